// [dv/test_timer8_pwm_phase_correct.sv]
module test_timer8_pwm_phase_correct
    import tmr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        pclk = 1'b0;
    logic        presetn;
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic        ext_count_pin;
    logic        ovf_vector_ack;
    logic        cmp_vector_ack;
    logic        overflow_flag;
    logic        compare_flag;
    logic        compare_out_pin;
    logic        compare_out_pin_oe_n;
    logic [31:0] rd;
    logic        perr;
    logic [31:0] lfsr = 32'hc60a;
    logic [7:0]  c;
    tmr_act_t    fa;
    int          k;
    int          n;
    int          miscompares = 0;
    int          tests_run = 0;

    always #4 pclk = ~pclk;

    tmr_timer8 dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .ext_count_pin, .ovf_vector_ack, .cmp_vector_ack, .overflow_flag, .compare_flag, .compare_out_pin,
        .compare_out_pin_oe_n);
    tmr_pin_model pin (.pclk, .ext_count_pin, .compare_out_pin, .compare_out_pin_oe_n);

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    function automatic logic [31:0] nxt_rand(logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic logic [31:0] ctl(logic f, tmr_mode_t m, tmr_act_t a, tmr_cs_t s);
        tmr_ctrl_t x;
        x = '{f, m[0], a, m[1], s};
        return {24'h0, x};
    endfunction

    task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic apb(logic w, logic [11:0] a, logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic reset_dut;
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b1, TMR_OFF_PINCTL, 32'h1);
    endtask

    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // run needs about 4.5k cycles; allow ample margin
    initial begin
        #400000;
        miscompares++;
        finish_test();
    end

    // ----------------------------------------------------------------
    // scenarios
    // ----------------------------------------------------------------
    initial begin
        presetn <= 1'b0;
        psel <= 1'b0;
        penable <= 1'b0;
        pwrite <= 1'b0;
        paddr <= TMR_OFF_CTRL;
        pwdata <= 32'h0;
        ovf_vector_ack <= 1'b0;
        cmp_vector_ack <= 1'b0;
        reset_dut();
        for (k = 0; k < 4; k++) begin
            apb(1'b0, 12'(4 * k), 32'h0);
            chk("reset value", rd, 32'h0);
        end
        apb(1'b0, 12'h0fc, 32'h0);
        chk("unmapped", {rd[30:0], perr}, 32'h1);
        chk("oe_n", 32'(compare_out_pin_oe_n), 32'h0);
        for (k = 0; k < 4; k++) begin
            lfsr = nxt_rand(lfsr);
            c = (k == 3) ? TMR_MAX : lfsr[7:0];
            n = int'(lfsr[10:8]) + 1;
            apb(1'b1, TMR_OFF_CTRL, ctl(1'b0, TMR_MODE_NORMAL, TMR_ACT_OFF, k[0] ? TMR_CS_EXTFALL : TMR_CS_EXTRISE));
            apb(1'b1, TMR_OFF_COUNT, {24'h0, c});
            apb(1'b1, TMR_OFF_FLAGS, 32'h3);
            pin.pulse(n);
            apb(1'b0, TMR_OFF_COUNT, 32'h0);
            chk("count", rd, {24'h0, c + 8'(n)});
            apb(1'b0, TMR_OFF_FLAGS, 32'h0);
            chk("overflow", 32'(rd[TMR_FLG_OVF_BIT]), 32'(9'(c) + 9'(n) > 9'h0ff));
        end
        @(posedge pclk);
        ovf_vector_ack <= 1'b1;
        cmp_vector_ack <= 1'b1;
        @(posedge pclk);
        ovf_vector_ack <= 1'b0;
        cmp_vector_ack <= 1'b0;
        @(posedge pclk);
        chk("ack", {30'h0, overflow_flag, compare_flag}, 32'h0);
        $display("end of counting");
        apb(1'b1, TMR_OFF_COMPARE, 32'h5);
        apb(1'b1, TMR_OFF_COUNT, 32'h5);
        for (k = 0; k < 3; k++) begin
            fa = (k == 0) ? TMR_ACT_SET : (k == 1) ? TMR_ACT_CLEAR : TMR_ACT_TOGGLE;
            apb(1'b1, TMR_OFF_CTRL, ctl(1'b1, TMR_MODE_CLRMAT, fa, TMR_CS_STOP));
            apb(1'b0, TMR_OFF_CTRL, 32'h0);
            chk("strobe", 32'(rd[7]), 32'h0);
            chk("forced", 32'(compare_out_pin), 32'(k != 1));
        end
        apb(1'b0, TMR_OFF_FLAGS, 32'h0);
        chk("forced flag", rd, 32'h0);
        apb(1'b0, TMR_OFF_COUNT, 32'h0);
        chk("forced count", rd, 32'h5);
        apb(1'b1, TMR_OFF_CTRL, ctl(1'b1, TMR_MODE_PHASE, TMR_ACT_CLEAR, TMR_CS_STOP));
        @(posedge pclk);
        chk("pwm force", 32'(compare_out_pin), 32'h1);
        apb(1'b1, TMR_OFF_CTRL, ctl(1'b0, TMR_MODE_CLRMAT, TMR_ACT_OFF, TMR_CS_EXTRISE));
        apb(1'b1, TMR_OFF_COUNT, 32'h5);
        pin.pulse(1);
        apb(1'b0, TMR_OFF_COUNT, 32'h0);
        chk("blocked", rd, 32'h6);
        apb(1'b1, TMR_OFF_COUNT, 32'h3);
        pin.pulse(2);
        // ack lands on the matching tick: the set must win
        fork
            pin.pulse(1);
            begin
                @(posedge pclk);
                cmp_vector_ack <= 1'b1;
                @(posedge pclk);
                cmp_vector_ack <= 1'b0;
            end
        join
        apb(1'b0, TMR_OFF_COUNT, 32'h0);
        chk("ctc clear", rd, 32'h0);
        apb(1'b0, TMR_OFF_FLAGS, 32'h0);
        chk("ctc flag", rd, 32'h1);
        $display("end of force and match");
        for (k = 0; k < 2; k++) begin
            fa = (k == 0) ? TMR_ACT_CLEAR : TMR_ACT_SET;
            reset_dut();
            apb(1'b1, TMR_OFF_COMPARE, 32'h80);
            apb(1'b1, TMR_OFF_COUNT, 32'h70);
            apb(1'b1, TMR_OFF_CTRL, ctl(1'b0, TMR_MODE_PHASE, fa, TMR_CS_EXTRISE));
            pin.pulse(20);
            chk("up match", 32'(compare_out_pin), 32'(k));
            pin.pulse(260);
            chk("down match", 32'(compare_out_pin), 32'(1 - k));
        end
        reset_dut();
        apb(1'b1, TMR_OFF_COUNT, 32'hfd);
        apb(1'b1, TMR_OFF_CTRL, ctl(1'b0, TMR_MODE_PHASE, TMR_ACT_OFF, TMR_CS_EXTRISE));
        pin.pulse(3);
        apb(1'b0, TMR_OFF_COUNT, 32'h0);
        chk("turn", rd, 32'hfe);
        pin.pulse(255);
        apb(1'b0, TMR_OFF_COUNT, 32'h0);
        chk("bottom", rd, 32'h1);
        apb(1'b0, TMR_OFF_FLAGS, 32'h0);
        chk("pc overflow", 32'(rd[TMR_FLG_OVF_BIT]), 32'h1);
        $display("end of dual slope");
        reset_dut();
        apb(1'b1, TMR_OFF_COMPARE, 32'h10);
        apb(1'b1, TMR_OFF_COUNT, 32'hfe);
        apb(1'b1, TMR_OFF_CTRL, ctl(1'b0, TMR_MODE_FAST, TMR_ACT_CLEAR, TMR_CS_EXTRISE));
        pin.pulse(2);
        chk("fast top", 32'(compare_out_pin), 32'h1);
        pin.pulse(17);
        chk("fast match", 32'(compare_out_pin), 32'h0);
        apb(1'b0, TMR_OFF_COUNT, 32'h0);
        chk("fast count", rd, 32'h11);
        $display("end of fast pwm");
        finish_test();
    end
endmodule

// [dv/tmr_pin_model.sv]
module tmr_pin_model (
    input  wire logic pclk,
    output logic      ext_count_pin,
    input  wire logic compare_out_pin,
    input  wire logic compare_out_pin_oe_n
);
    timeunit 1ns;
    timeprecision 1ps;

    initial ext_count_pin = 1'b0;

    // two cycles per level keeps each half period above one pclk
    task automatic pulse(input int n);
        repeat (n) begin
            @(posedge pclk);
            ext_count_pin <= 1'b1;
            repeat (2) @(posedge pclk);
            ext_count_pin <= 1'b0;
            repeat (2) @(posedge pclk);
        end
    endtask
endmodule

// [rtl/tmr_timer8.sv]
// Function
// - Mode 1 counts up BOTTOM to MAX then down to BOTTOM, repeating.
// - Dual-slope holds MAX one tick; eight-bit period is 510 ticks.
// - Dual-slope sets overflow flag at BOTTOM, not MAX.
// - Dual-slope action 10: clear on up match, set on down match.
// - Dual-slope action 11: set on up match, clear on down; 01 reserved.
// - Dual-slope compare BOTTOM gives constant low, MAX constant high; inverted opposite.
// - At MAX dual-slope output takes up-match result for symmetry, unless compare is MAX.
// - Per-mode TOP, compare update point and overflow point.
// - Mode low bit at control bit 6, high bit at bit 3.
// - Force strobe applies immediate match in non-PWM modes only.
// - Forced match sets no flag, clears no counter; strobe reads zero.
// - Nonzero action overrides pin; pin drives only with direction set.
// - Non-PWM action: 01 toggles, 10 clears, 11 sets.
// - Fast PWM: 10 clear on match set at TOP; 11 inverse.
// - PWM with compare equal TOP and high action bit: only TOP action.
// - Clock select: stop, div1, div8/64/256/1024, external fall, external rise.
// - External edges count even when the pin is an output.
// - Counter read/write; a write blocks match on the next tick.
// - Compare value compared continuously; match sets flag and drives wave.
// - Fully synchronous; timer tick is a one-cycle enable.
// - Clear-on-match mode clears counter at tick when count equals compare.
// - Normal mode wraps 0xFF to 0x00; overflow set when count becomes zero.
// - Fast PWM counts BOTTOM to MAX then restarts at BOTTOM.
// - Flags cleared by vector acknowledge or by writing one.
module tmr_timer8
    import tmr_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        ext_count_pin,
    input  wire logic        ovf_vector_ack,
    input  wire logic        cmp_vector_ack,
    output logic             overflow_flag,
    output logic             compare_flag,
    output logic             compare_out_pin,
    output logic             compare_out_pin_oe_n
);

    // ----------------------------------------------------------------
    // state
    // ----------------------------------------------------------------
    tmr_ctrl_t             ctrl_ff;
    logic [7:0]            count_ff;
    logic [7:0]            cmp_buf_ff;
    logic [7:0]            cmp_act_ff;
    logic                  down_ff;
    logic                  block_ff;
    logic                  ovf_ff;
    logic                  cmpf_ff;
    logic                  oc_ff;
    logic [1:0]            pinctl_ff;
    logic [TMR_PRE_W-1:0]  pre_ff;
    logic                  ext_prev_ff;
    logic [31:0]           prdata_ff;

    // ----------------------------------------------------------------
    // decode
    // ----------------------------------------------------------------
    tmr_mode_t  mode;
    tmr_ctrl_t  wr_ctrl;
    logic       is_pwm;
    logic       wr_en;
    logic       rd_setup;
    logic       addr_hit;
    logic       wr_ctrl_en;
    logic       wr_count_en;
    logic       wr_cmp_en;
    logic       wr_flags_en;
    logic       wr_pin_en;
    logic       tick;
    logic       at_max;
    logic       at_bottom;
    logic       match_raw;
    logic       match;
    logic       force_pulse;
    logic       top_tick;
    logic       ovf_set;
    logic [7:0] nxt_count;
    logic       nxt_down;
    logic       nxt_oc;

    assign mode     = tmr_mode_t'({ctrl_ff.wave_mode_hi, ctrl_ff.wave_mode_lo});
    assign is_pwm   = ctrl_ff.wave_mode_lo;
    assign wr_ctrl  = tmr_ctrl_t'(pwdata[TMR_CTRL_W-1:0]);
    assign wr_en    = psel && penable && pwrite;
    assign rd_setup = psel && !penable && !pwrite;

    assign addr_hit = (paddr == TMR_OFF_CTRL) || (paddr == TMR_OFF_COUNT) ||
                      (paddr == TMR_OFF_COMPARE) || (paddr == TMR_OFF_FLAGS) ||
                      (paddr == TMR_OFF_PINCTL);

    assign wr_ctrl_en  = wr_en && (paddr == TMR_OFF_CTRL);
    assign wr_count_en = wr_en && (paddr == TMR_OFF_COUNT);
    assign wr_cmp_en   = wr_en && (paddr == TMR_OFF_COMPARE);
    assign wr_flags_en = wr_en && (paddr == TMR_OFF_FLAGS);
    assign wr_pin_en   = wr_en && (paddr == TMR_OFF_PINCTL);

    // zero-wait slave; unmapped addresses answer with an error
    assign pready  = 1'b1;
    assign pslverr = psel && penable && !addr_hit;
    assign prdata  = prdata_ff;

    // ----------------------------------------------------------------
    // output action helper, shared by forced and real matches
    // ----------------------------------------------------------------
    function automatic logic tmr_apply(input tmr_act_t act, input logic cur);
        logic res;
        res = cur;
        unique case (act)
            TMR_ACT_OFF:    res = cur;
            TMR_ACT_TOGGLE: res = !cur;
            TMR_ACT_CLEAR:  res = 1'b0;
            TMR_ACT_SET:    res = 1'b1;
        endcase
        return res;
    endfunction

    // ----------------------------------------------------------------
    // prescaler and tick select
    // ----------------------------------------------------------------
    // free running: the first prescaled tick after enabling lands anywhere
    // within one divider period
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_ff <= '0;
        end else begin
            pre_ff <= pre_ff + TMR_PRE_ONE;
        end
    end

    // pin is sampled regardless of its direction setting
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ext_prev_ff <= 1'b0;
        end else begin
            ext_prev_ff <= ext_count_pin;
        end
    end

    always_comb begin
        tick = 1'b0;
        unique case (ctrl_ff.clk_source_sel)
            TMR_CS_STOP:    tick = 1'b0;
            TMR_CS_DIV1:    tick = 1'b1;
            TMR_CS_DIV8:    tick = (pre_ff & TMR_TAP8_MASK) == TMR_TAP8_MASK;
            TMR_CS_DIV64:   tick = (pre_ff & TMR_TAP64_MASK) == TMR_TAP64_MASK;
            TMR_CS_DIV256:  tick = (pre_ff & TMR_TAP256_MASK) == TMR_TAP256_MASK;
            TMR_CS_DIV1024: tick = (pre_ff & TMR_TAP1024_MASK) == TMR_TAP1024_MASK;
            TMR_CS_EXTFALL: tick = ext_prev_ff && !ext_count_pin;
            TMR_CS_EXTRISE: tick = !ext_prev_ff && ext_count_pin;
        endcase
    end

    // ----------------------------------------------------------------
    // compare and counter sequencing
    // ----------------------------------------------------------------
    assign at_max    = count_ff == TMR_MAX;
    assign at_bottom = count_ff == TMR_BOTTOM;
    assign match_raw = count_ff == cmp_act_ff;
    assign match     = tick && match_raw && !block_ff;
    assign top_tick  = tick && at_max && is_pwm;
    assign force_pulse = wr_ctrl_en && wr_ctrl.force_compare_strobe && !wr_ctrl.wave_mode_lo;

    always_comb begin
        nxt_count = count_ff;
        nxt_down  = down_ff;
        ovf_set   = 1'b0;
        unique case (mode)
            TMR_MODE_NORMAL: begin
                nxt_count = count_ff + TMR_ONE;
                ovf_set   = at_max;
            end
            TMR_MODE_CLRMAT: begin
                nxt_count = (match_raw && !block_ff) ? TMR_BOTTOM : count_ff + TMR_ONE;
                ovf_set   = at_max;
            end
            TMR_MODE_FAST: begin
                nxt_count = count_ff + TMR_ONE;
                ovf_set   = at_max;
            end
            TMR_MODE_PHASE: begin
                if (!down_ff) begin
                    if (at_max) begin
                        nxt_down  = 1'b1;
                        nxt_count = count_ff - TMR_ONE;
                    end else begin
                        nxt_count = count_ff + TMR_ONE;
                    end
                end else begin
                    if (at_bottom) begin
                        nxt_down  = 1'b0;
                        nxt_count = count_ff + TMR_ONE;
                        ovf_set   = 1'b1;
                    end else begin
                        nxt_count = count_ff - TMR_ONE;
                    end
                end
            end
        endcase
    end

    // software write wins over the tick; a forced match never clears it
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_ff <= TMR_COUNT_RST;
            down_ff  <= 1'b0;
        end else if (wr_count_en) begin
            count_ff <= pwdata[7:0];
        end else if (tick) begin
            count_ff <= nxt_count;
            down_ff  <= is_pwm && !ctrl_ff.wave_mode_hi && nxt_down;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            block_ff <= 1'b0;
        end else if (wr_count_en) begin
            block_ff <= 1'b1;
        end else if (tick) begin
            block_ff <= 1'b0;
        end
    end

    // ----------------------------------------------------------------
    // compare value: direct in non-PWM modes, buffered to TOP in PWM
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmp_buf_ff <= TMR_COMPARE_RST;
        end else if (wr_cmp_en) begin
            cmp_buf_ff <= pwdata[7:0];
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmp_act_ff <= TMR_COMPARE_RST;
        end else if (!is_pwm) begin
            cmp_act_ff <= wr_cmp_en ? pwdata[7:0] : cmp_buf_ff;
        end else if (top_tick) begin
            cmp_act_ff <= cmp_buf_ff;
        end
    end

    // ----------------------------------------------------------------
    // waveform generator
    // ----------------------------------------------------------------
    always_comb begin
        nxt_oc = oc_ff;
        unique case (mode)
            TMR_MODE_NORMAL, TMR_MODE_CLRMAT: begin
                if (match) begin
                    nxt_oc = tmr_apply(ctrl_ff.out_action_sel, oc_ff);
                end
            end
            TMR_MODE_FAST: begin
                if (ctrl_ff.out_action_sel[1]) begin
                    if (top_tick) begin
                        nxt_oc = !ctrl_ff.out_action_sel[0];
                    end else if (match) begin
                        nxt_oc = ctrl_ff.out_action_sel[0];
                    end
                end
            end
            TMR_MODE_PHASE: begin
                // at MAX the level is the up-match result unless compare is MAX, so a period that
                // skipped its up match still ends symmetric around BOTTOM
                if (ctrl_ff.out_action_sel[1]) begin
                    if (top_tick) begin
                        nxt_oc = (cmp_buf_ff == TMR_MAX) ? !ctrl_ff.out_action_sel[0]
                                                         : ctrl_ff.out_action_sel[0];
                    end else if (match && down_ff && !at_bottom) begin
                        nxt_oc = !ctrl_ff.out_action_sel[0];
                    end else if (match) begin
                        nxt_oc = ctrl_ff.out_action_sel[0];
                    end
                end
            end
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            oc_ff <= 1'b0;
        end else if (force_pulse) begin
            oc_ff <= tmr_apply(wr_ctrl.out_action_sel, oc_ff);
        end else begin
            oc_ff <= nxt_oc;
        end
    end

    always_comb begin
        compare_out_pin_oe_n = !pinctl_ff[TMR_PIN_DIR_BIT];
        if (ctrl_ff.out_action_sel != TMR_ACT_OFF) begin
            compare_out_pin = oc_ff;
        end else begin
            compare_out_pin = pinctl_ff[TMR_PIN_DAT_BIT];
        end
    end

    // ----------------------------------------------------------------
    // control and pin registers
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_ff <= tmr_ctrl_t'(TMR_CTRL_RST);
        end else if (wr_ctrl_en) begin
            ctrl_ff <= wr_ctrl;
            ctrl_ff.force_compare_strobe <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pinctl_ff <= 2'b00;
        end else if (wr_pin_en) begin
            pinctl_ff <= pwdata[1:0];
        end
    end

    // ----------------------------------------------------------------
    // flags: a set in the same cycle as a clear wins
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ovf_ff <= 1'b0;
        end else if (tick && ovf_set) begin
            ovf_ff <= 1'b1;
        end else if (ovf_vector_ack || (wr_flags_en && pwdata[TMR_FLG_OVF_BIT])) begin
            ovf_ff <= 1'b0;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cmpf_ff <= 1'b0;
        end else if (match) begin
            cmpf_ff <= 1'b1;
        end else if (cmp_vector_ack || (wr_flags_en && pwdata[TMR_FLG_CMP_BIT])) begin
            cmpf_ff <= 1'b0;
        end
    end

    assign overflow_flag = ovf_ff;
    assign compare_flag  = cmpf_ff;

    // ----------------------------------------------------------------
    // read data, captured in the setup cycle
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_ff <= '0;
        end else if (rd_setup) begin
            prdata_ff <= '0;
            unique case (paddr)
                TMR_OFF_CTRL:    prdata_ff[7:0] <= ctrl_ff;
                TMR_OFF_COUNT:   prdata_ff[7:0] <= count_ff;
                TMR_OFF_COMPARE: prdata_ff[7:0] <= cmp_buf_ff;
                TMR_OFF_FLAGS:   prdata_ff[1:0] <= {ovf_ff, cmpf_ff};
                TMR_OFF_PINCTL:  prdata_ff[1:0] <= pinctl_ff;
                default:         prdata_ff <= '0;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_force_write;
        wr_ctrl_en && pwdata[TMR_CTRL_W-1];
    endsequence

    sequence s_ctrl_read;
        rd_setup && (paddr == TMR_OFF_CTRL);
    endsequence

    sequence s_pc_top;
        tick && (mode == TMR_MODE_PHASE) && at_max && !down_ff && !wr_count_en;
    endsequence

    AST_PC_REVERSE: assert property (
        s_pc_top |=> down_ff && (count_ff == TMR_MAX - TMR_ONE))
        else $error("dual-slope did not reverse after MAX");

    AST_PC_OVF_BOTTOM: assert property (
        tick && (mode == TMR_MODE_PHASE) && down_ff && at_bottom && !wr_count_en |=> overflow_flag && !down_ff)
        else $error("overflow not set at BOTTOM");

    AST_PC_MAX_UPRESULT: assert property (
        s_pc_top ##0 (ctrl_ff.out_action_sel == TMR_ACT_CLEAR) ##0 (cmp_buf_ff != TMR_MAX)
        |=> !oc_ff)
        else $error("output at MAX not up-match result");

    AST_NORMAL_WRAP: assert property (
        tick && (mode == TMR_MODE_NORMAL) && at_max && !wr_count_en
        |=> (count_ff == TMR_BOTTOM) && overflow_flag)
        else $error("normal mode wrap or overflow wrong");

    AST_CTC_CLEAR: assert property (
        tick && (mode == TMR_MODE_CLRMAT) && match_raw && !block_ff && !wr_count_en |=> count_ff == TMR_BOTTOM)
        else $error("clear-on-match did not clear counter");

    AST_WRITE_BLOCKS: assert property (
        tick && block_ff && !compare_flag |=> !compare_flag)
        else $error("match not blocked after counter write");

    AST_FORCE_NO_FLAG: assert property (
        s_force_write ##0 !compare_flag ##0 !match |=> !compare_flag)
        else $error("forced compare raised the flag");

    AST_FORCE_READS_ZERO: assert property (
        s_force_write ##2 s_ctrl_read |=> !prdata[TMR_CTRL_W-1])
        else $error("force strobe read back as one");

    AST_FLAG_SET_WINS: assert property (
        match && (cmp_vector_ack || wr_flags_en) |=> compare_flag)
        else $error("compare flag clear beat the set");

    AST_PIN_OVERRIDE: assert property (
        (ctrl_ff.out_action_sel != TMR_ACT_OFF) |-> (compare_out_pin == oc_ff))
        else $error("compare output not routed to pin");

    AST_EXT_RISE: assert property (
        (ctrl_ff.clk_source_sel == TMR_CS_EXTRISE) && $rose(ext_count_pin) && !wr_count_en
        && (mode == TMR_MODE_NORMAL) |=> count_ff == $past(count_ff) + TMR_ONE)
        else $error("rising pin edge not counted");

endmodule

// [shared/tmr_pkg.sv]
package tmr_pkg;

    // ----------------------------------------------------------------
    // register map (byte addresses, one aligned word each)
    // ----------------------------------------------------------------
    localparam logic [11:0] TMR_OFF_CTRL    = 12'h000;
    localparam logic [11:0] TMR_OFF_COUNT   = 12'h004;
    localparam logic [11:0] TMR_OFF_COMPARE = 12'h008;
    localparam logic [11:0] TMR_OFF_FLAGS   = 12'h00c;
    localparam logic [11:0] TMR_OFF_PINCTL  = 12'h010;

    // ----------------------------------------------------------------
    // reset values and counter limits
    // ----------------------------------------------------------------
    localparam logic [7:0]  TMR_CTRL_RST    = 8'h00;
    localparam logic [7:0]  TMR_COUNT_RST   = 8'h00;
    localparam logic [7:0]  TMR_COMPARE_RST = 8'h00;
    localparam logic [7:0]  TMR_BOTTOM      = 8'h00;
    localparam logic [7:0]  TMR_MAX         = 8'hff;
    localparam logic [7:0]  TMR_ONE         = 8'h01;

    // ----------------------------------------------------------------
    // field positions outside the control word
    // ----------------------------------------------------------------
    localparam int unsigned TMR_FLG_CMP_BIT = 0;
    localparam int unsigned TMR_FLG_OVF_BIT = 1;
    localparam int unsigned TMR_PIN_DIR_BIT = 0;
    localparam int unsigned TMR_PIN_DAT_BIT = 1;
    localparam int unsigned TMR_CTRL_W      = 8;

    // ----------------------------------------------------------------
    // prescaler taps: a tap fires when the low bits are all ones
    // ----------------------------------------------------------------
    localparam int unsigned TMR_PRE_W       = 10;
    localparam logic [9:0]  TMR_TAP8_MASK    = 10'h007;
    localparam logic [9:0]  TMR_TAP64_MASK   = 10'h03f;
    localparam logic [9:0]  TMR_TAP256_MASK  = 10'h0ff;
    localparam logic [9:0]  TMR_TAP1024_MASK = 10'h3ff;
    localparam logic [9:0]  TMR_PRE_ONE      = 10'h001;

    typedef enum logic [1:0] {
        TMR_MODE_NORMAL = 2'b00,
        TMR_MODE_PHASE  = 2'b01,
        TMR_MODE_CLRMAT = 2'b10,
        TMR_MODE_FAST   = 2'b11
    } tmr_mode_t;

    typedef enum logic [1:0] {
        TMR_ACT_OFF    = 2'b00,
        TMR_ACT_TOGGLE = 2'b01,
        TMR_ACT_CLEAR  = 2'b10,
        TMR_ACT_SET    = 2'b11
    } tmr_act_t;

    typedef enum logic [2:0] {
        TMR_CS_STOP  = 3'b000,
        TMR_CS_DIV1  = 3'b001,
        TMR_CS_DIV8  = 3'b010,
        TMR_CS_DIV64 = 3'b011,
        TMR_CS_DIV256  = 3'b100,
        TMR_CS_DIV1024 = 3'b101,
        TMR_CS_EXTFALL = 3'b110,
        TMR_CS_EXTRISE = 3'b111
    } tmr_cs_t;

    // control word, bit 7 down to bit 0
    typedef struct packed {
        logic     force_compare_strobe;
        logic     wave_mode_lo;
        tmr_act_t out_action_sel;
        logic     wave_mode_hi;
        tmr_cs_t  clk_source_sel;
    } tmr_ctrl_t;

endpackage
